/* hdl/board_switch_remote_uart_ctrl.v */
// Virtual switch words, physical switch mirror and remote serial control
`include "board_switch_map.vh"
`default_nettype none

module board_switch_remote_uart_ctrl
#(
  parameter STANDBY_CYCLES = `STANDBY_CYCLES
)
(
  input  wire               pclk,                  // APB clock
  input  wire               presetn,               // Reset, active low
  input  wire               psel,                  // APB select
  input  wire               penable,               // APB enable
  input  wire               pwrite,                // APB direction
  input  wire [`ADDR_W-1:0] paddr,                 // APB byte address
  input  wire [31:0]        pwdata,                // APB write data
  output wire               pready,                // APB ready
  output reg  [31:0]        prdata,                // APB read data
  output reg                pslverr,               // APB error
  input  wire [7:0]         user_switch_setting,   // User setting
  input  wire [7:0]         config_switch_setting, // Config setting
  input  wire [1:0]         console_owner_setting, // Console owner
  input  wire               bootscript_switch_up,  // High when up
  input  wire               remote_switch_up,      // High when up
  input  wire               remote_standby_request,// Modem DSR line
  input  wire               remote_console_select, // Modem CTS line
  input  wire               hw_reset_button,       // Button pulse
  input  wire               power_on_button,       // Leave standby
  output reg                boot_autorun,          // Boot behaviour
  output reg                uart0_to_mcu,          // Port 0 owner
  output reg                uart1_to_mcu,          // Port 1 owner
  output reg                standby_active,        // Board in standby
  output reg                standby_request        // Entry pulse
);

  // ==========================================================
  // Board state codes
  localparam [1:0] S_LOAD    = 2'b00;
  localparam [1:0] S_RUN     = 2'b01;
  localparam [1:0] S_STANDBY = 2'b10;

  // Limit in clock cycles; 25 bits hold the full 100 ms count at 250 MHz
  localparam [`CNT_W-1:0] STANDBY_LIMIT = STANDBY_CYCLES[`CNT_W-1:0];

  // ==========================================================
  // Address match, shared by read and write decode
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Any of the four words; full match, so aliases are refused
  function mapped;
    input [`ADDR_W-1:0] addr;
    begin
      mapped = hit(addr, `OFF_USER_SW) |
               hit(addr, `OFF_CFG_SW) |
               hit(addr, `OFF_STATUS) |
               hit(addr, `OFF_STANDBY_CNT);
    end
  endfunction

  // Held state
  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg  [7:0]        user_sw;
  reg  [7:0]        cfg_sw;
  reg               sw_wrote;
  reg  [`CNT_W-1:0] high_cnt;
  reg               fired;
  reg  [31:0]       next_rdata;

  // Decoded and synchronised levels
  wire [1:0]        modem_sync;
  wire              dsr_s;
  wire              cts_s;
  wire              boot_on;
  wire              remote_on;
  wire              setup;
  wire              wr_access;
  wire              wr_user;
  wire              wr_cfg;
  wire              at_limit;
  wire              remote_fire;
  wire              go_standby;
  wire              user_bit0;

  // ==========================================================
  // Modem-control lines cross into the clock domain
  // Two edges of delay; negligible against the 100 ms count
  sync_two_flop
  #(
    .WIDTH (2)
  )
  u_modem_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({remote_console_select, remote_standby_request}),
    .dout  (modem_sync)
  );

  // Bit order follows the concatenation at the synchroniser input
  assign dsr_s = modem_sync[0];
  assign cts_s = modem_sync[1];

  // Up position is off, so on is the inverted level
  // Switches are slow levels taken as synchronous; no debounce here
  assign boot_on   = ~bootscript_switch_up;
  assign remote_on = ~remote_switch_up;

  // ==========================================================
  // APB decode; zero wait states, read data captured in setup
  // pready tied high, so every access ends in its first access cycle
  assign pready    = 1'b1;
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite & mapped(paddr);
  assign wr_user   = wr_access & hit(paddr, `OFF_USER_SW);
  assign wr_cfg    = wr_access & hit(paddr, `OFF_CFG_SW);

  // ==========================================================
  // Standby entry: remote request takes the button's own path
  assign at_limit    = (high_cnt == STANDBY_LIMIT);
  assign remote_fire = (state == S_RUN) & remote_on & dsr_s &
                       ~fired & at_limit;
  assign go_standby  = hw_reset_button | remote_fire;

  // Bit 0 at reload: a software value survives, else setting or switch
  assign user_bit0 = sw_wrote ? user_sw[`BIT_BOOT_AUTO] :
                     (boot_on | user_switch_setting[`BIT_BOOT_AUTO]);

  // ==========================================================
  // Board state sequence
  // Button and remote request share one path, so both behave alike
  always @*
  begin
    next_state = state;
    case (state)
      S_LOAD:
        next_state = S_RUN;
      S_RUN:
        if (go_standby)
          next_state = S_STANDBY;
      S_STANDBY:
        if (power_on_button)
          next_state = S_LOAD;
      default:
        next_state = S_LOAD;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= S_LOAD;
    else
      state <= next_state;
  end

  // ==========================================================
  // Virtual switch words; settings are caught after reset release,
  // never under the asynchronous reset itself
  // Writes in the load cycle lose to the reload
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      user_sw <= `USER_SW_RST;
      cfg_sw  <= `CFG_SW_RST;
    end
    else if (state == S_LOAD)
    begin
      user_sw <= {user_switch_setting[7:1], user_bit0};
      cfg_sw  <= config_switch_setting;
    end
    else
    begin
      if (wr_user)
        user_sw <= pwdata[7:0];
      if (wr_cfg)
        cfg_sw <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Software copy of bit 0 is remembered across board resets;
  // only a power-on reset of this logic forgets it
  // Trade-off: rewriting the old value still marks the bit as software's
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_wrote <= 1'b0;
    else if (wr_user)
      sw_wrote <= 1'b1;
  end

  // ==========================================================
  // Boot behaviour is latched only while loading, so a later
  // write to bit 0 waits for the next reset
  // Held through standby, so behaviour changes only at the reload
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_autorun <= 1'b0;
    else if (state == S_LOAD)
      boot_autorun <= user_bit0;
  end

  // ==========================================================
  // Standby request high-time counter; saturates at the limit so
  // one long pulse fires once, and a short pulse never fires
  // Limitation: a drop of one synchronised cycle restarts the count
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_cnt <= `CNT_ZERO;
      fired    <= 1'b0;
    end
    else if (!remote_on || !dsr_s || state != S_RUN)
    begin
      high_cnt <= `CNT_ZERO;
      fired    <= 1'b0;
    end
    else
    begin
      if (!at_limit)
        high_cnt <= high_cnt + `CNT_ONE;
      if (remote_fire)
        fired <= 1'b1;
    end
  end

  // ==========================================================
  // Standby outputs
  // Active level uses next_state, so it rises with the entry pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      standby_active  <= 1'b0;
      standby_request <= 1'b0;
    end
    else
    begin
      standby_active  <= (next_state == S_STANDBY);
      standby_request <= (state == S_RUN) & go_standby;
    end
  end

  // ==========================================================
  // Console ownership; remote select wins over the setting while
  // the remote switch is on, the setting holds otherwise
  // Limitation: the select line can give only the first port to the MCU; high also clears the second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uart0_to_mcu <= 1'b0;
      uart1_to_mcu <= 1'b0;
    end
    else if (remote_on)
    begin
      uart0_to_mcu <= cts_s;
      uart1_to_mcu <= ~cts_s &
                      (console_owner_setting == `OWNER_UART1);
    end
    else
    begin
      uart0_to_mcu <= (console_owner_setting == `OWNER_UART0);
      uart1_to_mcu <= (console_owner_setting == `OWNER_UART1);
    end
  end

  // ==========================================================
  // Read mux; the words are shown here and nowhere else
  // Unmapped offsets read as zero; the error flag marks them
  always @*
  begin
    next_rdata = `DATA_ZERO;
    if (hit(paddr, `OFF_USER_SW))
    begin
      next_rdata[7:0] = user_sw;
      next_rdata[`BIT_BOOT_SWITCH]   = boot_on;
      next_rdata[`BIT_REMOTE_SWITCH] = remote_on;
    end
    else if (hit(paddr, `OFF_CFG_SW))
      next_rdata[7:0] = cfg_sw;
    else if (hit(paddr, `OFF_STATUS))
    begin
      next_rdata[`ST_REMOTE_ON] = remote_on;
      next_rdata[`ST_DSR]       = dsr_s;
      next_rdata[`ST_CTS]       = cts_s;
      next_rdata[`ST_BOOT_AUTO] = boot_autorun;
      next_rdata[`ST_UART0_MCU] = uart0_to_mcu;
      next_rdata[`ST_UART1_MCU] = uart1_to_mcu;
      next_rdata[`ST_STANDBY]   = standby_active;
      next_rdata[`ST_LOADING]   = (state == S_LOAD);
      next_rdata[`ST_SW_WROTE]  = sw_wrote;
    end
    else if (hit(paddr, `OFF_STANDBY_CNT))
      next_rdata[`CNT_W-1:0] = high_cnt;
  end

  // ==========================================================
  // Read data and error are registered in the setup cycle, so the
  // access cycle answers at once with flop outputs
  // A write captures zero, so no stale read data leaks out
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `DATA_ZERO;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? `DATA_ZERO : next_rdata;
      pslverr <= ~mapped(paddr);
    end
  end

endmodule

`default_nettype wire

/* pkg/board_switch_map.vh */
// Address map, field positions, reset values and timing for the switch block
`ifndef BOARD_SWITCH_MAP_VH
`define BOARD_SWITCH_MAP_VH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define OFF_USER_SW     12'h000
`define OFF_CFG_SW      12'h004
`define OFF_STATUS      12'h008
`define OFF_STANDBY_CNT 12'h00C
`define ADDR_W          12

// ==========================================================
// Field positions
`define BIT_BOOT_AUTO     0
`define BIT_BOOT_SWITCH   30
`define BIT_REMOTE_SWITCH 31
`define ST_REMOTE_ON      0
`define ST_DSR            1
`define ST_CTS            2
`define ST_BOOT_AUTO      3
`define ST_UART0_MCU      4
`define ST_UART1_MCU      5
`define ST_STANDBY        6
`define ST_LOADING        7
`define ST_SW_WROTE       8

// ==========================================================
// Reset values
`define USER_SW_RST 8'h00
`define CFG_SW_RST  8'h00
`define DATA_ZERO   32'h00000000

// ==========================================================
// Console owner setting encodings
`define OWNER_DISABLED 2'h0
`define OWNER_UART0    2'h1
`define OWNER_UART1    2'h2

// ==========================================================
// Timing: least standby request high time
`define CLK_HZ         250000000
`define STANDBY_MIN_MS 100
`define STANDBY_CYCLES (`CLK_HZ / 1000 * `STANDBY_MIN_MS)
`define CNT_W          25
`define CNT_ZERO       25'h0000000
`define CNT_ONE        25'h0000001

`endif

/* hdl/sync_two_flop.v */
// Two-flop synchroniser for a group of independent level inputs
`default_nettype none

module sync_two_flop
#(
  parameter WIDTH = 2
)
(
  input  wire             clk,     // Sampling clock
  input  wire             rst_n,   // Asynchronous reset, active low
  input  wire [WIDTH-1:0] din,     // Asynchronous levels
  output wire [WIDTH-1:0] dout     // Synchronised levels
);

  genvar i;

  // ==========================================================
  // One flop pair per bit; the first flop feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg stage1;
      reg stage2;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end
        else
        begin
          stage1 <= din[i];
          stage2 <= stage1;
        end
      end
      assign dout[i] = stage2;
    end
  endgenerate

endmodule

`default_nettype wire

/* bench/board_switch_remote_uart_ctrl_assertions.sv */
// Port checker for the switch block
`default_nettype none
module board_switch_checker
#(
  parameter STANDBY_CYCLES = 20
)
(
  input wire logic        pclk,                   // Clock
  input wire logic        presetn,                // Reset, low
  input wire logic        psel,                   // Select
  input wire logic        penable,                // Enable
  input wire logic        pwrite,                 // Direction
  input wire logic [11:0] paddr,                  // Address
  input wire logic [31:0] prdata,                 // Read data
  input wire logic        pslverr,                // Error
  input wire logic [1:0]  console_owner_setting,  // Owner
  input wire logic        bootscript_switch_up,   // Boot up
  input wire logic        remote_switch_up,       // Remote up
  input wire logic        remote_standby_request, // Request line
  input wire logic        remote_console_select,  // Select line
  input wire logic        hw_reset_button,        // Button
  input wire logic        power_on_button,        // Button
  input wire logic        boot_autorun,           // Boot behaviour
  input wire logic        uart0_to_mcu,           // Port 0
  input wire logic        uart1_to_mcu,           // Port 1
  input wire logic        standby_active,         // Standby
  input wire logic        standby_request         // Entry pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hi_len;
  logic [31:0] on_hi;
  logic        was_low;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Run lengths: last request pulse is kept so a late entry is still judged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_len  <= 32'h0;
      on_hi   <= 32'h0;
      was_low <= 1'b1;
    end
    else
    begin
      was_low <= !remote_standby_request;
      if (remote_standby_request)
        hi_len <= was_low ? 32'h1 : hi_len + 32'h1;
      on_hi <= (remote_standby_request && !remote_switch_up) ? on_hi + 32'h1 : 32'h0;
    end
  end
  a_boot_mirror: assert property (psel && !penable && !pwrite && paddr == 12'h000 |=>
    prdata[30] == !$past(bootscript_switch_up)) else $error("boot mirror wrong");
  a_remote_mirror: assert property (psel && !penable && !pwrite && paddr == 12'h000 |=>
    prdata[31] == !$past(remote_switch_up)) else $error("remote mirror wrong");
  a_owner_first: assert property ((remote_switch_up && console_owner_setting == 2'h1
    && !standby_active)[*5] |-> uart0_to_mcu && !uart1_to_mcu) else $error("owner 1");
  a_owner_second: assert property ((remote_switch_up && console_owner_setting == 2'h2
    && !standby_active)[*5] |-> !uart0_to_mcu && uart1_to_mcu) else $error("owner 2");
  a_cts_console: assert property ((!remote_switch_up && remote_console_select
    && !standby_active)[*5] |-> uart0_to_mcu && !uart1_to_mcu) else $error("cts high");
  a_cts_system: assert property ((!remote_switch_up && !remote_console_select
    && !standby_active)[*5] |-> !uart0_to_mcu) else $error("cts low");
  a_entry_pulse: assert property ($rose(standby_active) |->
    standby_request ##1 !standby_request) else $error("entry pulse wrong");
  a_standby_holds: assert property (standby_active && !power_on_button |=>
    standby_active) else $error("standby dropped");
  a_remote_gate: assert property ($rose(standby_active) |->
    $past(hw_reset_button) || !$past(remote_switch_up)) else $error("remote gate");
  a_min_high: assert property ($rose(standby_active) && !$past(hw_reset_button) |->
    hi_len >= STANDBY_CYCLES) else $error("request too short");
  a_fire_bound: assert property (on_hi == STANDBY_CYCLES + 6 |->
    standby_active) else $error("standby late");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h00C |=>
    pslverr && prdata == 32'h00000000) else $error("unmapped not refused");
  a_boot_held: assert property ($past(presetn) && !standby_active
    && !$past(standby_active) |=> $stable(boot_autorun)) else $error("boot changed");
  c_standby: cover property ($rose(standby_active));
  c_error: cover property (pslverr);
  c_console: cover property (!remote_switch_up && uart0_to_mcu);
endmodule
bind board_switch_remote_uart_ctrl board_switch_checker #(.STANDBY_CYCLES(STANDBY_CYCLES)) u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .console_owner_setting(console_owner_setting),
  .bootscript_switch_up(bootscript_switch_up), .remote_switch_up(remote_switch_up),
  .remote_standby_request(remote_standby_request),
  .remote_console_select(remote_console_select), .hw_reset_button(hw_reset_button),
  .power_on_button(power_on_button), .boot_autorun(boot_autorun),
  .uart0_to_mcu(uart0_to_mcu),
  .uart1_to_mcu(uart1_to_mcu), .standby_active(standby_active),
  .standby_request(standby_request)
);
`default_nettype wire

/* bench/remote_farm_controller.sv */
// Test-farm controller model driving the modem-control lines
`default_nettype none
module remote_farm_controller
(
  input  wire logic pclk,                   // Bench clock
  output var  logic remote_standby_request, // Request line
  output var  logic remote_console_select   // Select line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial remote_standby_request = 1'b0;
  initial remote_console_select = 1'b0;
  // High pulse; a short one is a deliberate under-length request
  task hold_request(input int cycles);
    remote_standby_request <= 1'b1;
    repeat (cycles) @(posedge pclk);
    remote_standby_request <= 1'b0;
  endtask
  // Low hands the console to the system, high to the microcontroller
  task pick_console(input logic mcu);
    remote_console_select <= mcu;
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the switch block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STBY = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rng;
  logic [7:0]  user_set, cfg_set;
  logic [1:0]  owner;
  logic        boot_up, remote_up, dsr, cts, hw_btn, pwr_btn;
  logic [32:0] exp_q[$], mask_q[$], e, m;
  int          fails, compares, s;
  remote_farm_controller i_far (.pclk(pclk), .remote_standby_request(dsr),
    .remote_console_select(cts));
  board_switch_remote_uart_ctrl #(.STANDBY_CYCLES(STBY)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .user_switch_setting(user_set), .config_switch_setting(cfg_set),
    .console_owner_setting(owner), .bootscript_switch_up(boot_up),
    .remote_switch_up(remote_up), .remote_standby_request(dsr),
    .remote_console_select(cts), .hw_reset_button(hw_btn), .power_on_button(pwr_btn),
    .boot_autorun(), .uart0_to_mcu(), .uart1_to_mcu(), .standby_active(),
    .standby_request());
  always #2 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One transfer; idle edge after it so psel never changes twice at one edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] ev, input logic [32:0] mv);
    exp_q.push_back(ev);
    mask_q.push_back(mv);
    apb(1'b0, a, 32'h00000000);
  endtask
  // Monitor: error flag and read data against the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      e = exp_q.pop_front();
      m = mask_q.pop_front();
      compares++;
      if (((({pslverr, prdata} ^ e) & m) !== 33'h0))
      begin
        fails++;
        $display("unexpected at %0t: read %h expected %h", $time, {pslverr, prdata}, e);
      end
    end
  end
  // Watchdog
  initial
  begin
    repeat (4000) @(posedge pclk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, owner} = '0;
    {boot_up, remote_up, hw_btn, pwr_btn} = 4'b0100;
    rng = xs(32'h1D99);
    user_set = {rng[7:1], 1'b0};
    cfg_set = rng[15:8];
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(12'h000, {3'b001, 22'h0, user_set | 8'h01}, 33'h1C00000FF);
    rd(12'h004, {25'h0, cfg_set}, 33'h1000000FF);
    rd(12'h008, 33'h8, 33'h188);
    rd(12'h02C, 33'h100000000, 33'h1FFFFFFFF);
    boot_up <= 1'b1;
    remote_up <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(12'h000, {3'b010, 30'h0}, 33'h1C0000000);
    $display("test load done");
    apb(1'b1, 12'h000, 32'h000000FE);
    apb(1'b1, 12'h004, 32'h000000FF);
    rd(12'h000, 33'hFE, 33'hFF);
    rd(12'h004, 33'hFF, 33'h1000000FF);
    rd(12'h008, 33'h109, 33'h13F);
    hw_btn <= 1'b1;
    @(posedge pclk);
    hw_btn <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(12'h008, 33'h40, 33'h40);
    pwr_btn <= 1'b1;
    @(posedge pclk);
    pwr_btn <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h008, 33'h100, 33'h1C8);
    rd(12'h000, {25'h0, user_set}, 33'h0FF);
    rd(12'h004, {25'h0, cfg_set}, 33'h0FF);
    $display("test boot bit done");
    remote_up <= 1'b1;
    for (s = 0; s < 3; s++)
    begin
      owner <= s[1:0];
      i_far.pick_console(~s[0]);
      repeat (5) @(posedge pclk);
      rd(12'h008, {27'h0, s == 2, s == 1, 4'h0}, 33'h30);
    end
    remote_up <= 1'b0;
    for (s = 0; s < 2; s++)
    begin
      i_far.pick_console(s[0]);
      repeat (5) @(posedge pclk);
      rd(12'h008, {27'h0, s == 0, s == 1, 4'h0}, 33'h30);
    end
    $display("test console done");
    i_far.hold_request(10);
    repeat (6) @(posedge pclk);
    rd(12'h008, 33'h0, 33'h40);
    remote_up <= 1'b1;
    i_far.hold_request(STBY + 20);
    repeat (6) @(posedge pclk);
    rd(12'h008, 33'h0, 33'h40);
    remote_up <= 1'b0;
    i_far.hold_request(STBY + 20);
    rd(12'h008, 33'h40, 33'h40);
    rd(12'h00C, 33'h0, 33'h1FFFFFFFF);
    $display("test standby done");
    end_of_test();
  end
endmodule
`default_nettype wire
